// ===== rtl/sar_seq_pkg.sv
// Functional notes
// RULE1: Converter is powered while enable is set or burst conversions run.
// RULE2: Converter shuts down when enable is clear and no burst is running.
// RULE3: Start source selects busy write, external pin edge, timer 1 or timer 2.
// RULE4: Busy reads 1 during conversion and clears itself when it completes.
// RULE5: Busy falling edge sets end-of-conversion flag and raises enabled interrupt.
// RULE6: Result registers hold valid data whenever the end-of-conversion flag is set.
// RULE7: Software should poll the end-of-conversion flag, not the busy bit.
// RULE8: Timer 2 start uses low-byte overflow in 8-bit mode, high-byte otherwise.
// RULE9: Software should make port routing skip the external start pin.
// RULE10: Mode 10b converts at once on start and tracks whenever idle.
// RULE11: Software must leave minimum tracking time before starts in mode 10b.
// RULE12: Mode 01b tracks programmed time, converts, then leaves input high-impedance.
// RULE13: Mode 11b tracks programmed time, converts, then tracks continuously.
// RULE14: Software must not combine immediate-convert mode with burst mode.
// RULE15: Subsystem clock is system clock, or burst oscillator when burst enabled.
// RULE16: SAR clock is the subsystem clock divided by the divider field plus one.
// RULE17: Sequencer is idle, tracking or converting; tracking leads straight to conversion.
// RULE18: Timed tracking lasts tracking-time field plus 2 subsystem clock cycles.
// RULE19: Conversion takes 13 SAR clocks plus 2 subsystem clocks.
// RULE20: End-of-conversion flag sets only after the repeat count is accumulated.
// RULE21: SAR divider divides by field plus one; zero passes clock undivided.
// RULE22: Tracking-time field loads a down-counter on each timed convert start.
package sar_seq_pkg;
  localparam int CONV_SAR_CYCLES = 13;
  localparam int TRACK_EXTRA_CONVERTER_SUBSYSTEM_CLOCK = 2;
  localparam int BURST_OSC_MAX_MHZ = 25;
  localparam logic [1:0] START_BUSY_WRITE = 2'h0;
  localparam logic [1:0] START_EXT_PIN = 2'h1;
  localparam logic [1:0] START_TIMER1 = 2'h2;
  localparam logic [1:0] START_TIMER2 = 2'h3;
  localparam logic [1:0] TRACK_POST = 2'h1;
  localparam logic [1:0] TRACK_PRE = 2'h2;
  localparam logic [1:0] TRACK_DUAL = 2'h3;
  localparam logic [1:0] REPEAT_1 = 2'h0;
  localparam logic [1:0] REPEAT_4 = 2'h1;
  localparam logic [1:0] REPEAT_8 = 2'h2;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [1:0] STAGE_START = 2'h0;
  localparam logic [1:0] STAGE_SAR = 2'h1;
  localparam logic [1:0] STAGE_FINISH = 2'h2;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_TRACK, SEQ_CONVERT} seq_state_t;
endpackage

// ===== rtl/sar_clock_if.sv
`timescale 1ns/1ps
interface sar_clock_if #(parameter int DIV_W = 5);
  logic fclkTick;
  logic run;
  logic [DIV_W-1:0] divisor;
  logic sarTick;
  modport sequencer (output fclkTick, output run, output divisor, input sarTick);
  modport divider (input fclkTick, input run, input divisor, output sarTick);
endinterface

// ===== rtl/sar_tick_divider.sv
`timescale 1ns/1ps
module sar_tick_divider
  import sar_seq_pkg::*;
#(
  parameter int DIV_W = 5
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  sar_clock_if.divider sc
);
  logic [DIV_W-1:0] divCount;
  logic [DIV_W:0] helperFclk;

  // ----------------------------------------
  // Divide-by-field-plus-one tick generator.
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !sc.run) begin
      divCount <= '0;
      sc.sarTick <= 1'b0;
    end else if (sc.fclkTick) begin
      if (divCount == sc.divisor) begin // RULE21
        divCount <= '0;
        sc.sarTick <= 1'b1; // RULE16
      end else begin
        divCount <= divCount + 1'b1;
        sc.sarTick <= 1'b0;
      end
    end else begin
      sc.sarTick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !sc.run) begin
      helperFclk <= '0;
    end else if (sc.sarTick) begin
      helperFclk <= {{DIV_W{1'b0}}, sc.fclkTick};
    end else if (sc.fclkTick) begin
      helperFclk <= helperFclk + 1'b1;
    end
  end

  a_div_ratio: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE21
    sc.run && sc.sarTick && $stable(sc.divisor)
    |-> helperFclk == {1'b0, sc.divisor} + 1'b1)
    else $error("SAR tick spacing differs from divider field plus one.");
endmodule

// ===== rtl/sar_adc_conversion_sequencer.sv
`timescale 1ns/1ps
module sar_adc_conversion_sequencer
  import sar_seq_pkg::*;
#(
  parameter int DATA_W = 12,
  parameter int DIV_W = 5,
  parameter int TK_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic converterEnable,
  input wire logic burstEnable,
  input wire logic burstClockTick,
  input wire logic [1:0] startSourceSelect,
  input wire logic [1:0] trackingModeSelect,
  input wire logic [TK_W-1:0] trackingTimeField,
  input wire logic [DIV_W-1:0] sarClockDivider,
  input wire logic [1:0] repeatCountSelect,
  input wire logic busyWrite,
  input wire logic externalConvertStart,
  input wire logic timer1Overflow,
  input wire logic timer2LowOverflow,
  input wire logic timer2HighOverflow,
  input wire logic timer2EightBitMode,
  input wire logic [DATA_W-1:0] sampleData,
  input wire logic eocFlagClear,
  input wire logic eocIntEnable,
  output logic conversionBusy,
  output logic endOfConversionFlag,
  output logic interruptRequest,
  output logic converterPowered,
  output logic trackingActive,
  output logic convertingActive,
  output logic [7:0] resultHighByte,
  output logic [7:0] resultLowByte
);
  seq_state_t seqState;
  seq_state_t next_seqState;
  logic extPinLast;
  logic startEvent;
  logic startTaken;
  logic timedTrack;
  logic fclkTick;
  logic [TK_W+1:0] trackCount;
  logic [1:0] convStage;
  logic [4:0] sarCount;
  logic convDone;
  logic [4:0] repCount;
  logic [4:0] repTarget;
  logic finalConv;
  logic [15:0] accum;
  logic [15:0] next_accum;
  logic powerNext;
  logic idleTracks;

  sar_clock_if #(.DIV_W(DIV_W)) sc ();

  sar_tick_divider #(.DIV_W(DIV_W)) u_div (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sc(sc.divider)
  );

  // ----------------------------------------
  // Clocking and start selection.
  // ----------------------------------------
  assign fclkTick = burstEnable ? burstClockTick : 1'b1; // RULE15
  assign sc.fclkTick = fclkTick;
  assign sc.run = (seqState == SEQ_CONVERT) && (convStage == STAGE_SAR);
  assign sc.divisor = sarClockDivider; // RULE16

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      extPinLast <= 1'b0;
    end else begin
      extPinLast <= externalConvertStart;
    end
  end

  always_comb begin
    case (startSourceSelect) // RULE3
      START_BUSY_WRITE: startEvent = busyWrite;
      START_EXT_PIN: startEvent = externalConvertStart && !extPinLast;
      START_TIMER1: startEvent = timer1Overflow;
      START_TIMER2: startEvent = timer2EightBitMode ? timer2LowOverflow
                                                    : timer2HighOverflow; // RULE8
      default: startEvent = 1'b0;
    endcase
  end

  assign startTaken = (seqState == SEQ_IDLE) && startEvent && (converterEnable || burstEnable);
  assign timedTrack = (trackingModeSelect != TRACK_PRE);

  always_comb begin
    case (repeatCountSelect)
      REPEAT_1: repTarget = 5'd1;
      REPEAT_4: repTarget = 5'd4;
      REPEAT_8: repTarget = 5'd8;
      default: repTarget = 5'd16;
    endcase
  end

  assign convDone = (seqState == SEQ_CONVERT) && (convStage == STAGE_FINISH) && fclkTick;
  assign finalConv = convDone && (repCount + 5'd1 >= repTarget); // RULE20

  // ----------------------------------------
  // Sequencer state.
  // ----------------------------------------
  always_comb begin
    next_seqState = seqState;
    case (seqState) // RULE17
      SEQ_IDLE: begin
        if (startTaken) begin
          next_seqState = timedTrack ? SEQ_TRACK : SEQ_CONVERT; // RULE10
        end
      end
      SEQ_TRACK: begin
        if (fclkTick && trackCount == '0) begin
          next_seqState = SEQ_CONVERT; // RULE17
        end
      end
      SEQ_CONVERT: begin
        if (convDone) begin
          if (burstEnable && !finalConv && timedTrack) begin
            next_seqState = SEQ_TRACK;
          end else if (burstEnable && !finalConv) begin
            next_seqState = SEQ_CONVERT;
          end else begin
            next_seqState = SEQ_IDLE;
          end
        end
      end
      default: next_seqState = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      seqState <= SEQ_IDLE;
    end else begin
      seqState <= next_seqState;
    end
  end

  // ----------------------------------------
  // Tracking timer.
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      trackCount <= '0;
    end else if (next_seqState == SEQ_TRACK && seqState != SEQ_TRACK) begin
      trackCount <= {2'b00, trackingTimeField} + (TK_W+2)'(TRACK_EXTRA_CONVERTER_SUBSYSTEM_CLOCK - 1); // RULE22
    end else if (seqState == SEQ_TRACK && fclkTick && trackCount != '0) begin
      trackCount <= trackCount - 1'b1; // RULE18
    end
  end

  // ----------------------------------------
  // Conversion timer.
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b || seqState != SEQ_CONVERT || convDone) begin
      convStage <= STAGE_START;
      sarCount <= '0;
    end else if (convStage == STAGE_START && fclkTick) begin
      convStage <= STAGE_SAR; // RULE19
    end else if (convStage == STAGE_SAR && sc.sarTick) begin
      if (sarCount == 5'(CONV_SAR_CYCLES - 1)) begin
        convStage <= STAGE_FINISH; // RULE19
      end
      sarCount <= sarCount + 1'b1;
    end
  end

  // ----------------------------------------
  // Accumulation and result.
  // ----------------------------------------
  assign next_accum = (repCount == '0 ? 16'h0000 : accum) + 16'(sampleData);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      accum <= RESULT_RESET;
      repCount <= '0;
      resultHighByte <= RESULT_RESET[15:8];
      resultLowByte <= RESULT_RESET[7:0];
    end else if (convDone) begin
      accum <= next_accum;
      repCount <= finalConv ? 5'd0 : repCount + 1'b1; // RULE20
      if (finalConv) begin
        resultHighByte <= next_accum[15:8]; // RULE6
        resultLowByte <= next_accum[7:0];
      end
    end
  end

  // ----------------------------------------
  // Status flags and power.
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      conversionBusy <= 1'b0;
      convertingActive <= 1'b0;
    end else begin
      conversionBusy <= next_seqState != SEQ_IDLE; // RULE4
      convertingActive <= next_seqState == SEQ_CONVERT;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      endOfConversionFlag <= 1'b0;
    end else if (finalConv) begin
      endOfConversionFlag <= 1'b1; // RULE5
    end else if (eocFlagClear) begin
      endOfConversionFlag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      interruptRequest <= 1'b0;
    end else begin
      interruptRequest <= eocIntEnable && (finalConv || (endOfConversionFlag && !eocFlagClear)); // RULE5
    end
  end

  assign powerNext = converterEnable || next_seqState != SEQ_IDLE; // RULE1
  assign idleTracks = trackingModeSelect == TRACK_PRE || trackingModeSelect == TRACK_DUAL;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      converterPowered <= 1'b0;
      trackingActive <= 1'b0;
    end else begin
      converterPowered <= powerNext; // RULE2
      trackingActive <= next_seqState == SEQ_TRACK ||
                        (next_seqState == SEQ_IDLE && powerNext && idleTracks); // RULE12 RULE13
    end
  end

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  logic [TK_W+2:0] helperTrack;
  logic [TK_W-1:0] helperTk;
  logic [4:0] helperSar;

  always_ff @(posedge sys_clk) begin
    if (!rst_b || seqState != SEQ_TRACK) begin
      helperTrack <= '0;
      helperTk <= trackingTimeField;
    end else if (fclkTick) begin
      helperTrack <= helperTrack + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b || seqState != SEQ_CONVERT || convDone) begin
      helperSar <= '0;
    end else if (convStage == STAGE_SAR && sc.sarTick) begin
      helperSar <= helperSar + 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_power_on: assert property (converterEnable |=> converterPowered) // RULE1
    else $error("Converter not powered while enabled.");
  a_power_off: assert property ( // RULE2
    !converterEnable && next_seqState == SEQ_IDLE |=> !converterPowered)
    else $error("Converter powered while disabled and idle.");
  a_busy_clears: assert property (convDone && !burstEnable |=> !conversionBusy) // RULE4
    else $error("Busy did not clear after conversion.");
  a_eoc_set: assert property (finalConv |=> endOfConversionFlag && interruptRequest == $past(eocIntEnable)) // RULE5
    else $error("Flag or interrupt wrong at conversion end.");
  a_pre_direct: assert property ( // RULE10
    startTaken && trackingModeSelect == TRACK_PRE |=> seqState == SEQ_CONVERT ##1 convertingActive)
    else $error("Immediate mode did not convert at once.");
  a_post_hiz: assert property ( // RULE12
    seqState == SEQ_CONVERT && convDone && !burstEnable && trackingModeSelect == TRACK_POST
    |=> !trackingActive)
    else $error("Input tracked after conversion in post mode.");
  a_dual_track: assert property ( // RULE13
    convDone && !burstEnable && trackingModeSelect == TRACK_DUAL |=> trackingActive)
    else $error("Input not tracked after conversion in dual mode.");
  a_track_conv: assert property (seqState == SEQ_TRACK ##1 seqState != SEQ_TRACK // RULE17
    |-> seqState == SEQ_CONVERT)
    else $error("Tracking not followed by conversion.");
  a_track_len: assert property ( // RULE18
    seqState == SEQ_TRACK && next_seqState == SEQ_CONVERT
    |-> helperTrack + 1'b1 == {3'b000, helperTk} + (TK_W+3)'(TRACK_EXTRA_CONVERTER_SUBSYSTEM_CLOCK))
    else $error("Tracking length differs from field plus two.");
  a_sar_count: assert property (convDone |-> helperSar == 5'(CONV_SAR_CYCLES)) // RULE19
    else $error("Conversion did not take thirteen SAR clocks.");
  a_result_hold: assert property (endOfConversionFlag && !finalConv // RULE6
    |=> $stable(resultHighByte) && $stable(resultLowByte))
    else $error("Result changed while flag set without new result.");

  c_single: cover property (startTaken ##[1:300] finalConv);
  c_burst: cover property (burstEnable && startTaken ##[1:1000] finalConv);
  c_ext_start: cover property (startSourceSelect == START_EXT_PIN && startTaken);
  c_set_clear: cover property (finalConv && eocFlagClear);
endmodule

// ===== tb/start_source_model.sv
`timescale 1ns/1ps
module start_source_model
  import sar_seq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic fire,
  input wire logic [1:0] source,
  input wire logic wrongByte,
  input wire logic eightBit,
  output logic externalConvertStart,
  output logic timer1Overflow,
  output logic timer2LowOverflow,
  output logic timer2HighOverflow
);
  int pinHold;
  logic lowByte;

  initial begin
    externalConvertStart = 1'h0;
    timer1Overflow = 1'h0;
    timer2LowOverflow = 1'h0;
    timer2HighOverflow = 1'h0;
    pinHold = 0;
  end

  assign lowByte = eightBit ^ wrongByte;

  // ----------------------------------------
  // Start events
  // ----------------------------------------
  // Events change after the falling edge; overflows last one cycle.
  always @(negedge sys_clk) begin
    timer1Overflow <= 1'h0;
    timer2LowOverflow <= 1'h0;
    timer2HighOverflow <= 1'h0;
    if (pinHold > 0) begin
      pinHold <= pinHold - 1;
    end else begin
      externalConvertStart <= 1'h0;
    end
    if (fire) begin
      if (source == START_EXT_PIN) begin
        externalConvertStart <= 1'h1;
        pinHold <= 3;
      end
      timer1Overflow <= (source == START_TIMER1);
      timer2LowOverflow <= (source == START_TIMER2) && lowByte;
      timer2HighOverflow <= (source == START_TIMER2) && !lowByte;
    end
  end
endmodule

// ===== tb/sar_adc_conversion_sequencer_bench.sv
`timescale 1ns/1ps
module sar_adc_conversion_sequencer_bench;
  import sar_seq_pkg::*;
  logic sys_clk = 1'h0, rst_b = 1'h0, converterEnable = 1'h0, burstEnable = 1'h0;
  logic burstClockTick = 1'h0, busyWrite = 1'h0, timer2EightBitMode = 1'h0;
  logic eocFlagClear = 1'h0, eocIntEnable = 1'h0, fire = 1'h0, wrongByte = 1'h0;
  logic [1:0] startSourceSelect = 2'h0, trackingModeSelect = 2'h2, repeatCountSelect = 2'h0;
  logic [3:0] trackingTimeField = 4'h0;
  logic [4:0] sarClockDivider = 5'h00;
  logic [11:0] sampleData = 12'h000;
  logic externalConvertStart, timer1Overflow, timer2LowOverflow, timer2HighOverflow;
  logic conversionBusy, endOfConversionFlag, interruptRequest, converterPowered;
  logic trackingActive, convertingActive, prevFlag = 1'h0, prevConv = 1'h0;
  logic [7:0] resultHighByte, resultLowByte;
  int fail_count = 0, cmp_count = 0, trkCnt = 0, lastTrk = 0, convCnt = 0, convLen = 0;
  int base;
  logic [15:0] expQ[$];
  logic [11:0] v;

  sar_adc_conversion_sequencer dut (.sys_clk, .rst_b, .converterEnable, .burstEnable,
    .burstClockTick, .startSourceSelect, .trackingModeSelect, .trackingTimeField,
    .sarClockDivider, .repeatCountSelect, .busyWrite, .externalConvertStart, .timer1Overflow,
    .timer2LowOverflow, .timer2HighOverflow, .timer2EightBitMode, .sampleData, .eocFlagClear,
    .eocIntEnable, .conversionBusy, .endOfConversionFlag, .interruptRequest, .converterPowered,
    .trackingActive, .convertingActive, .resultHighByte, .resultLowByte);

  start_source_model partner (.sys_clk, .fire, .source(startSourceSelect), .wrongByte,
    .eightBit(timer2EightBitMode), .externalConvertStart, .timer1Overflow,
    .timer2LowOverflow, .timer2HighOverflow);

  // ----------------------------------------
  // Clock, watchdog and checks
  // ----------------------------------------
  always #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) burstClockTick <= burstEnable & ~burstClockTick;

  task automatic finish_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic expect_eq(input logic [15:0] got, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  initial begin
    #300_000;
    fail_count++;
    finish_test();
  end

  // Results are checked when the flag rises; run_one waits for the busy bit to clear for completion.
  always @(posedge sys_clk) begin
    prevFlag <= endOfConversionFlag;
    prevConv <= convertingActive;
    if (convertingActive === 1'h1) begin
      trkCnt <= 0;
      convCnt <= convCnt + 1;
    end else if (conversionBusy !== 1'h1) begin
      trkCnt <= 0;
    end else if (trackingActive === 1'h1) begin
      trkCnt <= trkCnt + 1;
    end
    if (convertingActive === 1'h1 && trkCnt != 0) lastTrk <= trkCnt;
    if (convertingActive !== 1'h1 && prevConv === 1'h1) begin
      convLen <= convCnt;
      convCnt <= 0;
    end
    if (rst_b && endOfConversionFlag === 1'h1 && prevFlag !== 1'h1) begin
      if (expQ.size() == 0) begin
        expect_eq(16'h0001, 16'h0000, "flag without conversion");
      end else begin
        expect_eq({resultHighByte, resultLowByte}, expQ.pop_front(), "result");
      end
      expect_eq(16'(interruptRequest), 16'(eocIntEnable), "interrupt");
    end
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  task automatic run_one(input logic [1:0] src, input logic [1:0] mode, input logic useBusy,
      input logic wrong, input logic go, input logic last, input logic [15:0] exp);
    int n;
    @(negedge sys_clk);
    startSourceSelect <= src;
    trackingModeSelect <= mode;
    wrongByte <= wrong;
    if (go && last) expQ.push_back(exp);
    repeat (4) @(negedge sys_clk);
    if (useBusy) busyWrite <= 1'h1;
    else fire <= 1'h1;
    @(negedge sys_clk);
    busyWrite <= 1'h0;
    fire <= 1'h0;
    n = 0;
    while (conversionBusy !== 1'h1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    expect_eq(16'(conversionBusy), 16'(go), "start taken");
    expect_eq(16'(converterPowered), 16'(converterEnable | go), "powered");
    if (go) begin
      n = 0;
      while (conversionBusy === 1'h1 && n < 4000) begin
        @(negedge sys_clk);
        n++;
      end
      @(negedge sys_clk);
      expect_eq(16'(endOfConversionFlag), 16'(last), "flag");
      expect_eq(16'(trackingActive), 16'(mode != TRACK_POST && converterEnable), "idle track");
      if (!burstEnable && mode != TRACK_PRE) begin
        expect_eq(16'(lastTrk), 16'(trackingTimeField) + 16'h0002, "track time");
      end
      base = CONV_SAR_CYCLES * (int'(sarClockDivider) + 1);
      cmp_count++;
      if (!burstEnable && (convLen < base + 1 || convLen > base + 3)) begin
        fail_count++;
        $display("unexpected at %0t: conversion length %0d", $time, convLen);
      end
      eocFlagClear <= last;
      @(negedge sys_clk);
      eocFlagClear <= 1'h0;
    end
  endtask

  initial begin
    v = 12'($urandom(78799));
    repeat (6) @(negedge sys_clk);
    rst_b <= 1'h1;
    @(negedge sys_clk);
    expect_eq({conversionBusy, endOfConversionFlag, interruptRequest, converterPowered,
      trackingActive, convertingActive, resultHighByte[1:0], resultLowByte}, 16'h0000, "reset");
    run_one(START_BUSY_WRITE, TRACK_PRE, 1'h1, 1'h0, 1'h0, 1'h1, 16'h0000);
    converterEnable <= 1'h1;
    eocIntEnable <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      sampleData <= 12'($urandom);
      timer2EightBitMode <= (i == 4);
      @(negedge sys_clk);
      run_one((i == 4) ? START_TIMER2 : 2'(i), TRACK_PRE, i == 0, 1'h0, 1'h1, 1'h1,
        {4'h0, sampleData});
    end
    run_one(START_TIMER2, TRACK_PRE, 1'h0, 1'h1, 1'h0, 1'h1, 16'h0000);
    run_one(START_EXT_PIN, TRACK_PRE, 1'h1, 1'h0, 1'h0, 1'h1, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      trackingTimeField <= (i == 0) ? 4'hF : 4'($urandom);
      sarClockDivider <= (i == 0) ? 5'h00 : 5'($urandom % 8);
      sampleData <= 12'($urandom);
      eocIntEnable <= i[0];
      @(negedge sys_clk);
      run_one(START_BUSY_WRITE, (i % 3 == 2) ? TRACK_PRE : 2'(1 + 2 * (i % 2)), 1'h1, 1'h0,
        1'h1, 1'h1, {4'h0, sampleData});
    end
    repeatCountSelect <= REPEAT_4;
    sampleData <= v;
    for (int i = 0; i < 4; i++) begin
      run_one(START_TIMER1, TRACK_DUAL, 1'h0, 1'h0, 1'h1, i == 3, {2'h0, v, 2'h0});
    end
    // Burst runs with a timed tracking mode and the enable bit clear.
    converterEnable <= 1'h0;
    burstEnable <= 1'h1;
    run_one(START_BUSY_WRITE, TRACK_POST, 1'h1, 1'h0, 1'h1, 1'h1, {2'h0, v, 2'h0});
    repeatCountSelect <= REPEAT_8;
    run_one(START_BUSY_WRITE, TRACK_DUAL, 1'h1, 1'h0, 1'h1, 1'h1, {1'h0, v, 3'h0});
    expect_eq(16'(converterPowered), 16'h0000, "burst off");
    finish_test();
  end
endmodule
